// ---- hw/sds_defs.svh ----
// Constants for the SMBus target data and status block
// Contract
// - Address byte 0 gives offset bits 7:0
// - Reads return full aligned 32-bit word
// - Writes use 8, 16 or 32 data bits
// - Data field is four byte lanes
// - Status byte precedes read data bytes
// - Status bit 7 flags 2 ms timeout
// - Status bit 5 flags master abort
// - Status bit 4 flags target abort
// - Status bit 0 flags previous success
// - Command bits 3:2 select internal operation
// - Command bit 5 selects address space
// - Byte count includes status on reads
// - Address byte 1 bits 3:0 give upper offset
`ifndef SDS_DEFS_SVH
`define SDS_DEFS_SVH
`define SDS_CMD_SIZE_LSB 2
`define SDS_CMD_CFG_BIT 5
`define SDS_ST_TIMEOUT 7
`define SDS_ST_MABORT 5
`define SDS_ST_TABORT 4
`define SDS_ST_OK 0
`define SDS_SIZE_RD32 2'h0
`define SDS_SIZE_WR8 2'h1
`define SDS_SIZE_WR16 2'h2
`define SDS_SIZE_WR32 2'h3
`define SDS_CLK_HZ 10000000
`define SDS_TIMEOUT_MS 2
`define SDS_TIMEOUT_CYC ((`SDS_CLK_HZ / 1000) * `SDS_TIMEOUT_MS)
`define SDS_RD_COUNT 8'h05
`endif

// ---- hw/sds_pkg.sv ----
// Types for the SMBus target data and status block
package sds_pkg;
	typedef struct packed {
		logic [7:0] data_lane_3;
		logic [7:0] data_lane_2;
		logic [7:0] data_lane_1;
		logic [7:0] data_lane_0;
	} sds_data_t;
	typedef struct packed {
		logic [7:0] command;
		logic [7:0] addr_hi;
		logic [7:0] addr_lo;
		sds_data_t data;
	} sds_req_t;
	typedef struct packed {
		logic cfg_mode;
		logic [11:0] offset;
		logic [3:0] byte_en;
		logic write;
		sds_data_t wdata;
	} sds_core_req_t;
	typedef enum logic [1:0] {SDS_IDLE, SDS_BUSY, SDS_SEND} sds_state_t;
endpackage

// ---- hw/sds_target.sv ----
// SMBus target data path: internal access, status byte and read stream
`timescale 1ns/10ps
`include "sds_defs.svh"
module sds_target #(
	parameter int unsigned TIMEOUT_CYC = `SDS_TIMEOUT_CYC
) (
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic req_valid,
	input wire sds_pkg::sds_req_t req,
	output sds_pkg::sds_core_req_t core_req,
	output logic core_valid,
	input wire logic core_done,
	input wire logic core_master_abort,
	input wire logic core_target_abort,
	input wire sds_pkg::sds_data_t core_rdata,
	output logic busy,
	output logic [7:0] status,
	output sds_pkg::sds_data_t rd_data,
	output logic [7:0] byte_count,
	output logic [7:0] tx_byte,
	output logic tx_valid,
	input wire logic tx_ready
);
	import sds_pkg::*;
	typedef struct packed {
		sds_state_t state;
		logic busy;
		sds_core_req_t core_req;
		logic core_valid;
		logic is_read;
		logic [7:0] status;
		sds_data_t rd_data;
		logic [7:0] byte_count;
		logic [7:0] tx_byte;
		logic tx_valid;
		logic [2:0] tx_idx;
	} sds_st_t;
	sds_st_t st, next_st;
	logic expired;
	logic [1:0] size;
	logic [3:0] be;
	logic [31:0] lane_mask;

	// Timer runs only while an internal access is outstanding
	sds_timer #(
		.LIMIT(TIMEOUT_CYC)
	) u_timer (
		.mclk(mclk),
		.reset_n(reset_n),
		.run(st.state == SDS_BUSY),
		.expired(expired)
	);

	always_comb begin
		size = req.command[`SDS_CMD_SIZE_LSB +: 2];
		case (size)
			`SDS_SIZE_WR8: be = 4'h1;
			`SDS_SIZE_WR16: be = 4'h3;
			default: be = 4'hf;
		endcase
	end

	// One mask byte per lane, driven from the decoded byte enables
	for (genvar i = 0; i < 4; i++) begin : g_lane
		assign lane_mask[8 * i +: 8] = {8{be[i]}};
	end

	always_comb begin
		next_st = st;
		case (st.state)
			SDS_IDLE: begin
				if (req_valid) begin
					next_st.core_req.cfg_mode = req.command[`SDS_CMD_CFG_BIT];
					// Upper nibble of the high address byte is dropped
					next_st.core_req.offset = {req.addr_hi[3:0], req.addr_lo};
					next_st.core_req.byte_en = be;
					next_st.core_req.write = (size != `SDS_SIZE_RD32);
					// Unused lanes are zeroed so the core never sees stale bytes
					next_st.core_req.wdata = req.data & lane_mask;
					next_st.is_read = (size == `SDS_SIZE_RD32);
					next_st.core_valid = 1'b1;
					next_st.state = SDS_BUSY;
				end
			end
			SDS_BUSY: begin
				if (core_done || expired) begin
					next_st.core_valid = 1'b0;
					next_st.status = 8'h00;
					next_st.status[`SDS_ST_TIMEOUT] = expired && !core_done;
					next_st.status[`SDS_ST_MABORT] = core_done && core_master_abort;
					next_st.status[`SDS_ST_TABORT] = core_done && core_target_abort;
					next_st.status[`SDS_ST_OK] = core_done && !core_master_abort
						&& !core_target_abort;
					if (st.is_read && core_done) begin
						next_st.rd_data = core_rdata;
					end
					if (st.is_read) begin
						next_st.byte_count = `SDS_RD_COUNT;
						next_st.state = SDS_SEND;
						next_st.tx_idx = 3'h0;
						next_st.tx_valid = 1'b0;
					end else begin
						next_st.state = SDS_IDLE;
					end
				end
			end
			SDS_SEND: begin
				if (!st.tx_valid || tx_ready) begin
					if (st.tx_idx == 3'h6) begin
						next_st.tx_valid = 1'b0;
						next_st.state = SDS_IDLE;
					end else begin
						next_st.tx_valid = 1'b1;
						next_st.tx_idx = st.tx_idx + 3'h1;
						case (st.tx_idx)
							3'h0: next_st.tx_byte = st.byte_count;
							3'h1: next_st.tx_byte = st.status;
							3'h2: next_st.tx_byte = st.rd_data.data_lane_3;
							3'h3: next_st.tx_byte = st.rd_data.data_lane_2;
							3'h4: next_st.tx_byte = st.rd_data.data_lane_1;
							default: next_st.tx_byte = st.rd_data.data_lane_0;
						endcase
					end
				end
			end
			default: next_st.state = SDS_IDLE;
		endcase
		// Busy is registered so the port comes straight from a flop
		next_st.busy = (next_st.state != SDS_IDLE);
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign core_req = st.core_req;
	assign core_valid = st.core_valid;
	assign busy = st.busy;
	assign status = st.status;
	assign rd_data = st.rd_data;
	assign byte_count = st.byte_count;
	assign tx_byte = st.tx_byte;
	assign tx_valid = st.tx_valid;
endmodule

// ---- hw/sds_timer.sv ----
// Access time counter with timeout flag
`timescale 1ns/10ps
`include "sds_defs.svh"
module sds_timer #(
	parameter int unsigned LIMIT = 20000
) (
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic run,
	output logic expired
);
	import sds_pkg::*;
	typedef struct packed {
		logic [31:0] count;
		logic expired;
	} sds_timer_st_t;
	sds_timer_st_t st, next_st;
	always_comb begin
		next_st = st;
		if (!run) begin
			next_st.count = 32'h0;
			next_st.expired = 1'b0;
		end else if (st.count >= LIMIT - 1) begin
			next_st.expired = 1'b1;
		end else begin
			next_st.count = st.count + 32'h1;
		end
	end
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end
	assign expired = st.expired;
endmodule

// ---- tb/sds_checker.sv ----
// Assertions on the target block ports
`timescale 1ns/10ps
module sds_checker (
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic req_valid,
	input wire sds_pkg::sds_req_t req,
	input wire sds_pkg::sds_core_req_t core_req,
	input wire logic core_valid,
	input wire logic core_done,
	input wire logic core_master_abort,
	input wire logic busy,
	input wire logic [7:0] status,
	input wire logic [7:0] tx_byte,
	input wire logic tx_valid
);
	import sds_pkg::*;
	sds_req_t r;
	logic t, d;
	assign t = req_valid && !busy;
	assign d = core_valid && core_done;
	always_ff @(posedge mclk) r <= req;
	default clocking @(posedge mclk); endclocking
	default disable iff (!reset_n);
	pad_zero_a:
	assert property ((status & 8'h4e) == 8'h00) else $error("pad");
	low_offset_a:
	assert property (t |=> core_req.offset == {r.addr_hi[3:0], r.addr_lo}) else $error("offset");
	addr_space_a:
	assert property (t |=> core_req.cfg_mode == r.command[5]) else $error("space");
	op_kind_a:
	assert property (t |=> core_valid && core_req.write == |r.command[3:2]) else $error("op");
	byte_lane_a:
	assert property (t && req.command[3:2] == 2'h1 |=>
		core_req.wdata == {24'h000000, r.data[7:0]}) else $error("b");
	word_lane_a:
	assert property (t && req.command[3:2] == 2'h2 |=>
		core_req.wdata == {16'h0000, r.data[15:0]}) else $error("w");
	master_abort_a:
	assert property (d |=> status[5] == $past(core_master_abort)) else $error("abort");
	count_first_a:
	assert property ($rose(tx_valid) |-> tx_byte == 8'h05) else $error("count");
	cover property (d && core_master_abort);
	cover property (status[7]);
	cover property ($rose(tx_valid));
endmodule
bind sds_target sds_checker u_sds_checker (.mclk, .reset_n, .req_valid, .req, .core_req,
	.core_valid, .core_done, .core_master_abort, .busy, .status, .tx_byte, .tx_valid);

// ---- tb/sds_core_model.sv ----
// Model of the internal register path
`timescale 1ns/10ps
module sds_core_model (
	input wire logic mclk,
	input wire logic core_valid,
	input wire logic [7:0] dly,
	input wire logic [1:0] err,
	output logic core_done,
	output logic [1:0] abt,
	output sds_pkg::sds_data_t core_rdata
);
	import sds_pkg::*;
	logic [7:0] n = 8'h00;
	always @(posedge mclk) n <= core_valid && !core_done ? n + 8'h01 : 8'h00;
	assign core_done = core_valid && n == dly;
	// Flags and data are junk outside a completion
	assign abt = core_done ? err : 2'h3;
	assign core_rdata = core_done ? 32'h11223344 : {4{8'h5a ^ n}};
endmodule

// ---- tb/sds_target_tb.sv ----
// Testbench for the target block
`timescale 1ns/10ps
module sds_target_tb;
	import sds_pkg::*;
	logic mclk = 0, reset_n = 0, req_valid = 0, tx_ready = 0, busy, tx_valid, core_valid, core_done;
	logic [7:0] status, tx_byte, byte_count, dly = 8'h03, q[$];
	logic [1:0] err = 2'h0, abt;
	sds_req_t req = '0;
	sds_core_req_t core_req;
	sds_data_t rd_data, core_rdata;
	int err_total = 0, compares = 0;
	sds_target #(.TIMEOUT_CYC(20)) u_sds_target (.mclk, .reset_n, .req_valid, .req, .core_req,
		.core_valid, .core_done, .core_master_abort(abt[1]), .core_target_abort(abt[0]),
		.core_rdata, .busy, .status, .rd_data, .byte_count, .tx_byte, .tx_valid, .tx_ready);
	sds_core_model u_sds_core_model (.mclk, .core_valid, .dly, .err, .core_done, .abt, .core_rdata);
	always #50 mclk = ~mclk;
	always @(posedge mclk) tx_ready <= #1 ~tx_ready;
	always @(negedge mclk) if (tx_valid && tx_ready) q.push_back(tx_byte);
	task automatic chk(string n, logic [31:0] s, logic [31:0] e);
		compares++;
		if (s !== e) begin
			err_total++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic cmd(logic [7:0] c);
		q.delete();
		@(posedge mclk) #1 req_valid = 1;
		req = {c, 8'ha5, 8'h3c, 32'hdeadbeef};
		@(posedge mclk) #1 req_valid = 0;
		repeat (300) if (busy !== 1'b0) @(posedge mclk) #1;
		// A command that never releases busy is a hang, not a pass
		if (busy !== 1'b0) begin
			err_total++;
			$display("Error busy expected 0 seen %b", busy);
		end
	endtask
	task automatic complete_run;
		$display("compares %0d errors %0d", compares, err_total);
		if (err_total == 0 && compares > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	initial begin
		#200000;
		err_total++;
		complete_run;
	end
	initial begin
		repeat (12) @(posedge mclk);
		#1 reset_n = 1;
		cmd(8'h20);
		chk("offset", core_req.offset, 12'h53c);
		chk("rdata", rd_data, 32'h11223344);
		chk("head", {q[0], q[1], q[2], q[3]}, 32'h05011122);
		chk("tail", {q[4], q[5]}, 16'h3344);
		chk("count", byte_count, 8'h05);
		chk("mode", {core_req.cfg_mode, core_req.write, core_req.byte_en}, 6'h2f);
		for (int s = 1; s < 4; s++) begin
			cmd({4'h0, s[1:0], 2'h0});
			chk("wdata", core_req.wdata, 32'hdeadbeef & ~(32'hffffffff << (8 << (s - 1))));
			chk("op", {core_req.cfg_mode, core_req.write, status}, 10'h101);
			chk("lanes", core_req.byte_en, (32'h1 << (1 << (s - 1))) - 32'h1);
		end
		for (int e = 1; e < 4; e++) begin
			err = e[1:0];
			cmd(8'h20);
			chk("abort", status, e << 4);
			chk("lead", q[1], e << 4);
		end
		err = 2'h0;
		dly = 8'h28;
		cmd(8'h2c);
		chk("late", status, 8'h80);
		dly = 8'h00;
		cmd(8'h20);
		chk("prompt", status, 8'h01);
		complete_run;
	end
endmodule
